//--- src/cbe_top.sv
// branch sequencer: evaluates flag conditions and loads the program counter
`timescale 1ns/1ns
module cbe_top
    import cbe_pkg::*;
#(
    parameter int PC_W = CBE_PC_W,
    parameter int K_W  = CBE_K_W
) (
    input  wire logic            mclk,
    input  wire logic            rst,
    input  wire logic            issue_valid,
    output logic                 issue_ready,
    input  wire logic [2:0]      issue_op,
    input  wire logic [K_W-1:0]  issue_k,
    input  wire logic [PC_W-1:0] issue_pc,
    input  wire logic            flag_c,
    input  wire logic            flag_n,
    input  wire logic            flag_v,
    output logic                 pc_load,
    output logic [PC_W-1:0]      pc_value,
    output logic                 br_taken,
    output logic                 stall,
    output logic                 flag_wr_en
);

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        CBE_IDLE  = 1'b0,
        CBE_SECND = 1'b1
    } cbe_state_e;

    cbe_state_e        state_q;
    logic [PC_W-1:0]   target_q;
    logic              pc_load_q;
    logic [PC_W-1:0]   pc_value_q;
    logic              br_taken_q;
    logic              accept;
    logic              cond_true;
    logic [PC_W-1:0]   seq_pc;
    logic [PC_W-1:0]   jump_pc;

    cbe_cond_if cif ();

    // ------------------------------------------------------------
    // condition evaluation
    // ------------------------------------------------------------
    assign cif.op     = issue_op;
    assign cif.flag_c = flag_c;
    assign cif.flag_n = flag_n;
    assign cif.flag_v = flag_v;
    assign cond_true  = cif.cond_true;

    cbe_cond u_cond (
        .cif (cif)
    );

    // ------------------------------------------------------------
    // address arithmetic
    // ------------------------------------------------------------
    // k is sign-extended so backward jumps wrap correctly inside PC_W bits
    assign seq_pc  = PC_W'(issue_pc + PC_W'(1));
    assign jump_pc = PC_W'(seq_pc + {{(PC_W-K_W){issue_k[K_W-1]}}, issue_k});

    // ------------------------------------------------------------
    // handshake
    // ------------------------------------------------------------
    // no new branch while the taken one uses its second cycle
    assign issue_ready = (state_q == CBE_IDLE);
    assign accept      = issue_valid & issue_ready;

    // ------------------------------------------------------------
    // state: a taken branch costs one extra cycle
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= CBE_IDLE;
        end else begin
            unique case (state_q)
                CBE_IDLE: begin
                    if (accept && cond_true) begin
                        state_q <= CBE_SECND;
                    end
                end
                CBE_SECND: begin
                    state_q <= CBE_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // jump target held over the extra cycle
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            target_q <= '0;
        end else if (accept && cond_true) begin
            target_q <= jump_pc;
        end
    end

    // ------------------------------------------------------------
    // program counter load
    // ------------------------------------------------------------
    // fall-through loads pc+1 one edge after issue, a taken jump two edges after
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pc_load_q  <= 1'b0;
            pc_value_q <= '0;
            br_taken_q <= 1'b0;
        end else if (state_q == CBE_SECND) begin
            pc_load_q  <= 1'b1;
            pc_value_q <= target_q;
            br_taken_q <= 1'b1;
        end else if (accept && !cond_true) begin
            pc_load_q  <= 1'b1;
            pc_value_q <= seq_pc;
            br_taken_q <= 1'b0;
        end else begin
            pc_load_q  <= 1'b0;
            br_taken_q <= 1'b0;
        end
    end

    assign pc_load    = pc_load_q;
    assign pc_value   = pc_value_q;
    assign br_taken   = br_taken_q;
    assign stall      = (state_q == CBE_SECND);
    // branches never write the status register
    assign flag_wr_en = CBE_FLAG_WE_RST;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic [2:0] op_c;
    assign op_c = issue_op;

    a_carry_clear_jump: assert property (
        accept && op_c == jump_on_carry_zero && !flag_c |=> stall ##1 (pc_load && br_taken))
        else $error("carry-zero jump did not take two cycles");

    a_not_below_jump: assert property (
        accept && op_c == jump_unsigned_not_below |=> (stall == !$past(flag_c)))
        else $error("unsigned not-below jump used the wrong carry test");

    a_below_jump: assert property (
        accept && op_c == jump_unsigned_below |=> (pc_load && !br_taken) == !$past(flag_c))
        else $error("unsigned below jump ignored carry");

    a_negative_jump: assert property (
        accept && op_c == jump_on_negative && flag_n |-> ##(CBE_CYC_TAKEN) pc_load && br_taken)
        else $error("negative jump not taken");

    a_nonneg_jump: assert property (
        accept && op_c == jump_on_nonnegative && flag_n |=> pc_load && !br_taken && !stall)
        else $error("nonnegative jump taken with negative flag set");

    a_signed_jump: assert property (
        accept && op_c == jump_signed_not_less |=> stall == !($past(flag_n) ^ $past(flag_v)))
        else $error("signed not-less jump used the wrong test");

    a_fall_through_pc: assert property (
        accept && !cond_true |=> pc_load && pc_value == $past(issue_pc) + PC_W'(1))
        else $error("fall-through did not load pc plus one");

    a_taken_target: assert property (
        accept && cond_true |-> ##2 pc_value == $past(jump_pc, 2))
        else $error("taken jump loaded a wrong target");

    a_flags_kept: assert property (
        !flag_wr_en)
        else $error("branch wrote the status flags");

    a_stall_blocks: assert property (
        stall |-> !issue_ready ##1 !stall)
        else $error("stall lasted more than one cycle or accepted issue");

    c_taken:        cover property (accept && cond_true ##2 pc_load && br_taken);
    c_fall_through: cover property (accept && !cond_true ##1 pc_load && !br_taken);
    c_back_to_back: cover property (accept && !cond_true ##1 accept);
    c_signed_taken: cover property (accept && op_c == jump_signed_not_less && flag_n && flag_v);

endmodule

//--- pkg/cbe_pkg.sv
// package of shared types, constants and decode for the conditional branch evaluator
package cbe_pkg;

    // ------------------------------------------------------------
    // branch operations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        jump_on_carry_zero      = 3'h0,
        jump_unsigned_not_below = 3'h1,
        jump_unsigned_below     = 3'h2,
        jump_on_negative        = 3'h3,
        jump_on_nonnegative     = 3'h4,
        jump_signed_not_less    = 3'h5
    } cbe_op_e;

    // ------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------
    localparam int CBE_PC_W        = 16; // default program counter width
    localparam int CBE_K_W         = 7;  // default signed word displacement width
    localparam int CBE_CYC_FALL    = 1;  // cycles for a branch not taken
    localparam int CBE_CYC_TAKEN   = 2;  // cycles for a branch taken
    localparam logic CBE_FLAG_WE_RST = 1'b0; // flag write enable never asserted

    // ------------------------------------------------------------
    // condition decode, called only by the evaluator cbe_cond
    // ------------------------------------------------------------
    function automatic logic cbe_cond_fn(input logic [2:0] op,
                                         input logic       c,
                                         input logic       n,
                                         input logic       v);
        logic r;
        r = 1'b0;
        case (op)
            jump_on_carry_zero:      r = ~c;
            jump_unsigned_not_below: r = ~c;
            jump_unsigned_below:     r = c;
            jump_on_negative:        r = n;
            jump_on_nonnegative:     r = ~n;
            jump_signed_not_less:    r = ~(n ^ v);
            default:                 r = 1'b0; // unused codes fall through
        endcase
        return r;
    endfunction

endpackage

//--- pkg/cbe_cond_if.sv
// interface between the branch sequencer and its condition evaluator
`timescale 1ns/1ns
interface cbe_cond_if;
    logic [2:0] op;
    logic       flag_c;
    logic       flag_n;
    logic       flag_v;
    logic       cond_true;

    modport eval (input op, input flag_c, input flag_n, input flag_v, output cond_true);
    modport user (output op, output flag_c, output flag_n, output flag_v, input cond_true);
endinterface

//--- src/cbe_cond.sv
// combinational condition evaluator for the carry, sign and signed-compare branches
`timescale 1ns/1ns
module cbe_cond
    import cbe_pkg::*;
(
    cbe_cond_if.eval cif
);

    // ------------------------------------------------------------
    // condition decode
    // ------------------------------------------------------------
    // pure logic: the status flags are only read here, never written
    assign cif.cond_true = cbe_cond_fn(cif.op, cif.flag_c, cif.flag_n, cif.flag_v);

endmodule

//--- tb/tb_top.sv
// self-checking testbench for the conditional branch evaluator
`timescale 1ns/1ns
module tb_top;
    import cbe_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        issue_valid = 1'b0;
    logic        issue_ready;
    logic [2:0]  issue_op = 3'h0;
    logic [6:0]  issue_k = 7'h00;
    logic [15:0] issue_pc = 16'h0000;
    logic        flag_c = 1'b0;
    logic        flag_n = 1'b0;
    logic        flag_v = 1'b0;
    logic        pc_load;
    logic [15:0] pc_value;
    logic        br_taken;
    logic        stall;
    logic        flag_wr_en;
    int          failures = 0;
    int          n_checks = 0;

    cbe_top #(.PC_W(16), .K_W(7)) dut (.mclk(mclk), .rst(rst), .issue_valid(issue_valid),
        .issue_ready(issue_ready), .issue_op(issue_op), .issue_k(issue_k), .issue_pc(issue_pc),
        .flag_c(flag_c), .flag_n(flag_n), .flag_v(flag_v), .pc_load(pc_load), .pc_value(pc_value),
        .br_taken(br_taken), .stall(stall), .flag_wr_en(flag_wr_en));

    // 125 MHz core clock
    always #4 mclk = ~mclk;

    // --------------------------------------------------------
    // compare and closing helpers
    // --------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // condition worked out independently of the design's decode
    function automatic logic exp_cond(input logic [2:0] op, input logic c, input logic n, input logic v);
        case (op)
            3'h0, 3'h1: return ~c;
            3'h2:       return c;
            3'h3:       return n;
            3'h4:       return ~n;
            3'h5:       return ~(n ^ v);
            default:    return 1'b0;
        endcase
    endfunction

    // target is the incremented counter plus the sign-extended word offset, wrapping
    function automatic logic [15:0] target(input logic [15:0] pc, input logic [6:0] k, input logic tk);
        return tk ? pc + 16'h0001 + {{9{k[6]}}, k} : pc + 16'h0001;
    endfunction

    // --------------------------------------------------------
    // one branch: present, accept, then check timing and result
    // --------------------------------------------------------
    task automatic run_br(input logic [2:0] op, input logic [2:0] f, input logic [6:0] k, input logic [15:0] pc);
        logic tk;
        tk = exp_cond(op, f[2], f[1], f[0]);
        @(posedge mclk);
        issue_valid <= 1'b1;
        issue_op    <= op;
        issue_k     <= k;
        issue_pc    <= pc;
        {flag_c, flag_n, flag_v} <= f;
        @(posedge mclk);
        issue_valid <= 1'b0;
        #1;
        if (tk) begin
            chk({15'h0000, stall}, 16'h0001);
            chk({15'h0000, pc_load}, 16'h0000);
            chk({15'h0000, issue_ready}, 16'h0000);
            @(posedge mclk);
            #1;
        end
        chk({15'h0000, pc_load}, 16'h0001);
        chk({15'h0000, br_taken}, {15'h0000, tk});
        chk(pc_value, target(pc, k, tk));
        chk({15'h0000, flag_wr_en}, 16'h0000);
    endtask

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task automatic t_reset();
        chk({15'h0000, issue_ready}, 16'h0001);
        chk({14'h0000, pc_load, stall}, 16'h0000);
        chk(pc_value, 16'h0000);
        $display("test reset done");
    endtask

    // every code against every flag combination, offsets of both signs, counter wrap
    task automatic t_all_ops();
        for (int op = 0; op < 8; op++) begin
            for (int f = 0; f < 8; f++) begin
                run_br(3'(op), 3'(f), 7'(op * 19 + f * 13), 16'hFFFC + 16'(f));
            end
        end
        $display("test all ops done");
    endtask

    // taken branch with the next request held through the stall, then back-to-back fall-through
    task automatic t_held();
        @(posedge mclk);
        issue_valid <= 1'b1;
        issue_op    <= 3'h0;
        issue_k     <= 7'h40;
        issue_pc    <= 16'h0100;
        {flag_c, flag_n, flag_v} <= 3'b000;
        @(posedge mclk);
        issue_op <= 3'h2;
        issue_pc <= 16'h0200;
        #1;
        chk({15'h0000, stall}, 16'h0001);
        @(posedge mclk);
        #1;
        chk({15'h0000, pc_load}, 16'h0001);
        chk(pc_value, 16'h00C1);
        @(posedge mclk);
        issue_pc <= 16'h0300;
        #1;
        chk({15'h0000, pc_load}, 16'h0001);
        chk(pc_value, 16'h0201);
        @(posedge mclk);
        issue_valid <= 1'b0;
        #1;
        chk({14'h0000, pc_load, br_taken}, 16'h0002);
        chk(pc_value, 16'h0301);
        @(posedge mclk);
        #1;
        chk({15'h0000, pc_load}, 16'h0000);
        $display("test held request done");
    endtask

    // watchdog sized well beyond the roughly 160 cycles the tests need
    initial begin
        repeat (3000) @(posedge mclk);
        failures++;
        $display("Error at %0t: watchdog expired got %h expected %h", $time, 1'b1, 1'b0);
        close_out();
    end

    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        t_reset();
        t_all_ops();
        t_held();
        close_out();
    end
endmodule
